/* File: hw/bmc_buf2.sv */
`timescale 1ns/1ps
// two-entry buffer, in order, full throughput
module bmc_buf2 #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic         clk_en,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] slot_r [2];
	logic [1:0]   cnt_r;
	logic         push;
	logic         pop;

	// handshake terms
	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = slot_r[0];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// fill level
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cnt_r <= 2'h0;
		end else if (clk_en) begin
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// head slot shifts on pop, new word lands behind the survivors
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			slot_r[0] <= '0;
			slot_r[1] <= '0;
		end else if (clk_en) begin
			if (pop) begin
				slot_r[0] <= slot_r[1];
			end
			if (push) begin
				if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) begin
					slot_r[0] <= in_data;
				end else begin
					slot_r[1] <= in_data;
				end
			end
		end
	end
endmodule

/* File: hw/bmc_pkg.sv */
package bmc_pkg;
	// widths of the decoded elements
	localparam int VW      = 13; // reconstructed vector, signed
	localparam int CODE_W  = 5;  // motion code, signed -16..15
	localparam int RES_W   = 6;  // motion residual
	localparam int FC_W    = 3;  // scale code
	localparam int INCR_W  = 11; // address increment
	localparam int POS_W   = 6;  // block row and column index
	localparam int BLK_W   = 3;  // block position within the macroblock
	localparam int PIX_W   = 8;
	localparam int RESID_W = 9;  // residual sample, -256..255
	localparam int OUT_W   = PIX_W + 2 * POS_W + BLK_W + 1;
	// vector component slots
	localparam int FR = 0;
	localparam int FD = 1;
	localparam int BR = 2;
	localparam int BD = 3;
	// vector range constants
	localparam int WRAP_MUL  = 32;
	localparam int RANGE_MUL = 16;
	// sample limits
	localparam logic signed [10:0] PIX_MAX = 11'sh0FF;
	localparam logic signed [10:0] PIX_MIN = 11'sh000;
	localparam logic [INCR_W-1:0]  INCR_ONE = 11'h001;
	typedef enum logic [1:0] {PIC_I, PIC_P, PIC_B} bmc_pic_type;
	typedef enum logic [1:0] {ST_IDLE, ST_SKIP, ST_VEC, ST_PIX} bmc_state_type;
endpackage

/* File: hw/bmc_recon.sv */
`timescale 1ns/1ps
// Overview of operation
// - B: clear previous vectors at slice start, after intra
// - B: missing forward data reuses previous forward
// - backward vector built like forward, backward inputs
// - backward size is code minus one, shifted
// - forward only: predict from past picture
// - backward only: predict from future picture
// - both: rounded average of two predictions
// - skipped or uncoded block: residual zero
// - residual accepted within -256..255
// - add residual, clamp 0..255, tag position
// - increment above one means skipped macroblocks, outside I pictures
// - P skip: zero vector, no residual
// - B skip: prior type, zero differential, no residual
// - no half flags: direct displaced sample
// - luma whole part by shift, remainder half flag
module bmc_recon
	import bmc_pkg::*;
(
	input  wire logic                        mclk,
	input  wire logic                        sys_rst,
	input  wire logic                        clk_en,
	// macroblock header from the parser
	input  wire logic                        hdr_valid,
	output logic                             hdr_ready,
	input  wire bmc_pkg::bmc_pic_type        hdr_pic,
	input  wire logic                        hdr_first_in_slice,
	input  wire logic [bmc_pkg::INCR_W-1:0]  hdr_addr_incr,
	input  wire logic                        hdr_intra,
	input  wire logic                        hdr_motion_fwd,
	input  wire logic                        hdr_motion_bwd,
	input  wire logic [bmc_pkg::FC_W-1:0]    hdr_fwd_f_code,
	input  wire logic [bmc_pkg::FC_W-1:0]    hdr_bwd_f_code,
	input  wire logic                        hdr_fwd_full_pel,
	input  wire logic                        hdr_bwd_full_pel,
	input  wire logic signed [4:0]           hdr_fwd_h_code,
	input  wire logic [bmc_pkg::RES_W-1:0]   hdr_fwd_h_resid,
	input  wire logic signed [4:0]           hdr_fwd_v_code,
	input  wire logic [bmc_pkg::RES_W-1:0]   hdr_fwd_v_resid,
	input  wire logic signed [4:0]           hdr_bwd_h_code,
	input  wire logic [bmc_pkg::RES_W-1:0]   hdr_bwd_h_resid,
	input  wire logic signed [4:0]           hdr_bwd_v_code,
	input  wire logic [bmc_pkg::RES_W-1:0]   hdr_bwd_v_resid,
	input  wire logic [bmc_pkg::POS_W-1:0]   hdr_block_row_index,
	input  wire logic [bmc_pkg::POS_W-1:0]   hdr_block_col_index,
	// vectors of the macroblock now being rebuilt
	output logic                             vec_valid,
	output logic                             vec_skipped,
	output logic                             vec_use_fwd,
	output logic                             vec_use_bwd,
	output logic signed [3:0][bmc_pkg::VW-1:0] vec_recon,
	output logic signed [3:0][bmc_pkg::VW-1:0] vec_whole,
	output logic [3:0]                       vec_half,
	// reference and residual samples
	input  wire logic                        smp_valid,
	output logic                             smp_ready,
	input  wire logic                        smp_last,
	input  wire logic [bmc_pkg::BLK_W-1:0]   smp_blk,
	input  wire logic                        smp_coded,
	input  wire logic [bmc_pkg::PIX_W-1:0]   smp_past_a,
	input  wire logic [bmc_pkg::PIX_W-1:0]   smp_past_b,
	input  wire logic [bmc_pkg::PIX_W-1:0]   smp_fut_a,
	input  wire logic [bmc_pkg::PIX_W-1:0]   smp_fut_b,
	input  wire logic signed [bmc_pkg::RESID_W-1:0] smp_resid,
	// reconstructed samples
	output logic                             pix_valid,
	input  wire logic                        pix_ready,
	output logic [bmc_pkg::PIX_W-1:0]        pix_data,
	output logic [bmc_pkg::POS_W-1:0]        pix_block_row_index,
	output logic [bmc_pkg::POS_W-1:0]        pix_block_col_index,
	output logic [bmc_pkg::BLK_W-1:0]        pix_blk,
	output logic                             pix_last
);
	import bmc_pkg::*;

	// one component of vector recovery against its previous value
	function automatic logic signed [VW-1:0] mv_recon(input logic signed [VW-1:0] prev,
		input logic signed [4:0] code, input logic [RES_W-1:0] res, input logic [FC_W-1:0] fcode);
		int f;
		int comp;
		int little;
		int big;
		int nv;
		f = 1 << (int'(fcode) - 1);
		comp = (f == 1 || code == 5'sh00) ? 0 : f - 1 - int'(res);
		little = int'(code) * f;
		big = 0;
		if (little > 0) begin
			little = little - comp;
			big = little - WRAP_MUL * f;
		end else if (little < 0) begin
			little = little + comp;
			big = little + WRAP_MUL * f;
		end
		nv = int'(prev) + little;
		if (nv > RANGE_MUL * f - 1 || nv < -RANGE_MUL * f) begin
			nv = int'(prev) + big;
		end
		return signed'(VW'(nv));
	endfunction

	bmc_state_type             state_r;
	bmc_state_type             state_nxt;
	bmc_pic_type               pic_r;
	logic                      first_r;
	logic                      intra_r;
	logic [1:0]                pres_r;
	logic [1:0]                full_r;
	logic [FC_W-1:0]           fcode_r [2];
	logic signed [4:0]         code_r [4];
	logic [RES_W-1:0]          res_r [4];
	logic [POS_W-1:0]          row_r;
	logic [POS_W-1:0]          col_r;
	logic [INCR_W-1:0]         skip_cnt_r;
	logic                      pend_r;
	logic                      last_intra_r;
	logic                      last_fwd_r;
	logic signed [VW-1:0]      prev_r [4];
	logic signed [VW-1:0]      prev_nxt [4];
	logic signed [VW-1:0]      vec_r [4];
	logic signed [VW-1:0]      vec_nxt [4];
	logic signed [VW-1:0]      skip_vec [4];
	logic                      use_fwd_r;
	logic                      use_bwd_r;
	logic                      skip_r;
	logic                      vec_valid_r;
	logic                      is_b;
	logic [1:0]                clr;
	logic                      hdr_take;
	logic                      smp_take;
	logic                      buf_in_ready;

	// header side terms
	assign is_b      = (pic_r == PIC_B);
	assign hdr_ready = (state_r == ST_IDLE);
	assign hdr_take  = hdr_valid & hdr_ready;
	assign clr[0]    = first_r | (is_b ? last_intra_r : ~last_fwd_r);
	assign clr[1]    = first_r | last_intra_r;

	// per component vector recovery, forward then backward slots
	for (genvar i = 0; i < 4; i++) begin : g_comp
		localparam int D = i / 2;
		logic signed [VW-1:0] base;
		logic signed [VW-1:0] calc;
		assign base = clr[D] ? '0 : prev_r[i];
		assign calc = mv_recon(base, code_r[i], res_r[i], fcode_r[D]);
		assign prev_nxt[i] = pres_r[D] ? calc : (is_b ? base : '0);
		assign vec_nxt[i] = full_r[D] ? {prev_nxt[i][VW-2:0], 1'b0} : prev_nxt[i];
		assign skip_vec[i] = is_b ? (full_r[D] ? {prev_r[i][VW-2:0], 1'b0} : prev_r[i]) : '0;
		assign vec_recon[i] = vec_r[i];
		assign vec_whole[i] = vec_r[i] >>> 1;
		assign vec_half[i] = vec_r[i][0];
	end

	// sequencing of skipped and coded macroblocks
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (hdr_take) begin
					state_nxt = (hdr_addr_incr > INCR_ONE && hdr_pic != PIC_I) ? ST_SKIP : ST_VEC;
				end
			end
			ST_SKIP: begin
				state_nxt = ST_PIX;
			end
			ST_VEC: begin
				state_nxt = ST_PIX;
			end
			ST_PIX: begin
				if (smp_take && smp_last) begin
					state_nxt = (skip_cnt_r != '0) ? ST_SKIP : (pend_r ? ST_VEC : ST_IDLE);
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// header capture
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pic_r   <= PIC_I;
			first_r <= 1'b0;
			intra_r <= 1'b0;
			pres_r  <= 2'h0;
			full_r  <= 2'h0;
			row_r   <= '0;
			col_r   <= '0;
			for (int i = 0; i < 4; i++) begin
				code_r[i] <= '0;
				res_r[i]  <= '0;
			end
			fcode_r[0] <= 3'h1;
			fcode_r[1] <= 3'h1;
		end else if (clk_en && hdr_take) begin
			pic_r      <= hdr_pic;
			first_r    <= hdr_first_in_slice;
			intra_r    <= hdr_intra;
			pres_r     <= {hdr_motion_bwd & ~hdr_intra, hdr_motion_fwd & ~hdr_intra};
			full_r     <= {hdr_bwd_full_pel, hdr_fwd_full_pel};
			row_r      <= hdr_block_row_index;
			col_r      <= hdr_block_col_index;
			fcode_r[0] <= hdr_fwd_f_code;
			fcode_r[1] <= hdr_bwd_f_code;
			code_r[FR] <= hdr_fwd_h_code;
			code_r[FD] <= hdr_fwd_v_code;
			code_r[BR] <= hdr_bwd_h_code;
			code_r[BD] <= hdr_bwd_v_code;
			res_r[FR]  <= hdr_fwd_h_resid;
			res_r[FD]  <= hdr_fwd_v_resid;
			res_r[BR]  <= hdr_bwd_h_resid;
			res_r[BD]  <= hdr_bwd_v_resid;
		end
	end

	// skip count and pending coded macroblock
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			skip_cnt_r <= '0;
			pend_r     <= 1'b0;
		end else if (clk_en) begin
			if (hdr_take) begin
				skip_cnt_r <= (hdr_pic != PIC_I && hdr_addr_incr > INCR_ONE) ? hdr_addr_incr - INCR_ONE : '0;
				pend_r     <= 1'b1;
			end else if (state_r == ST_SKIP) begin
				skip_cnt_r <= skip_cnt_r - INCR_ONE;
			end else if (state_r == ST_VEC) begin
				pend_r <= 1'b0;
			end
		end
	end

	// vector state and prediction mode per macroblock
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				prev_r[i] <= '0;
				vec_r[i]  <= '0;
			end
			use_fwd_r    <= 1'b0;
			use_bwd_r    <= 1'b0;
			skip_r       <= 1'b0;
			last_intra_r <= 1'b0;
			last_fwd_r   <= 1'b0;
			vec_valid_r  <= 1'b0;
		end else if (clk_en) begin
			vec_valid_r <= (state_r == ST_SKIP) || (state_r == ST_VEC);
			if (state_r == ST_SKIP) begin
				for (int i = 0; i < 4; i++) begin
					vec_r[i] <= skip_vec[i];
				end
				skip_r <= 1'b1;
				if (!is_b) begin
					use_fwd_r  <= 1'b1;
					use_bwd_r  <= 1'b0;
					last_fwd_r <= 1'b0;
				end
			end else if (state_r == ST_VEC) begin
				skip_r       <= 1'b0;
				last_intra_r <= intra_r;
				last_fwd_r   <= pres_r[0];
				use_fwd_r    <= ~intra_r & (pres_r[0] | ~is_b);
				use_bwd_r    <= ~intra_r & is_b & pres_r[1];
				for (int i = 0; i < 4; i++) begin
					if (!intra_r) begin
						prev_r[i] <= prev_nxt[i];
					end
					vec_r[i] <= intra_r ? '0 : vec_nxt[i];
				end
			end
		end
	end

	assign vec_valid   = vec_valid_r;
	assign vec_skipped = skip_r;
	assign vec_use_fwd = use_fwd_r;
	assign vec_use_bwd = use_bwd_r;

	// prediction per sample
	logic        half_f;
	logic        half_b;
	logic [8:0]  pred_f;
	logic [8:0]  pred_b;
	logic [8:0]  pred_fb;
	logic [8:0]  pred;
	logic signed [10:0] sum;
	logic [PIX_W-1:0]   recon;
	logic [OUT_W-1:0]   buf_in;
	logic [OUT_W-1:0]   buf_out;

	assign half_f  = vec_half[FR] | vec_half[FD];
	assign half_b  = vec_half[BR] | vec_half[BD];
	assign pred_f  = half_f ? (({1'b0, smp_past_a} + {1'b0, smp_past_b} + 9'h001) >> 1) : {1'b0, smp_past_a};
	assign pred_b  = half_b ? (({1'b0, smp_fut_a} + {1'b0, smp_fut_b} + 9'h001) >> 1) : {1'b0, smp_fut_a};
	assign pred_fb = (pred_f + pred_b + 9'h001) >> 1;
	assign pred    = (use_fwd_r & use_bwd_r) ? pred_fb : (use_fwd_r ? pred_f : (use_bwd_r ? pred_b : 9'h000));

	// residual add and clamp; the residual port spans exactly -256..255
	assign sum = signed'({2'b00, pred}) + ((skip_r | ~smp_coded) ? 11'sh000 : 11'(smp_resid));
	assign recon = (sum > PIX_MAX) ? 8'hFF : ((sum < PIX_MIN) ? 8'h00 : sum[PIX_W-1:0]);

	// stall back to the sample source when the buffer is full
	assign smp_ready = (state_r == ST_PIX) & buf_in_ready;
	assign smp_take  = smp_valid & smp_ready;
	assign buf_in    = {recon, row_r, col_r, smp_blk, smp_last};

	bmc_buf2 #(
		.W(OUT_W)
	) u_buf (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.clk_en   (clk_en),
		.in_valid (smp_valid & (state_r == ST_PIX)),
		.in_ready (buf_in_ready),
		.in_data  (buf_in),
		.out_valid(pix_valid),
		.out_ready(pix_ready),
		.out_data (buf_out)
	);

	assign {pix_data, pix_block_row_index, pix_block_col_index, pix_blk, pix_last} = buf_out;
endmodule

/* File: tb/bmc_recon_sva.sv */
`timescale 1ns/1ps
// port-level checks of header, vector and sample handshakes
module bmc_recon_sva
	import bmc_pkg::*;
(
	input wire logic                              mclk,
	input wire logic                              sys_rst,
	input wire logic                              clk_en,
	input wire logic                              hdr_valid,
	input wire logic                              hdr_ready,
	input wire bmc_pkg::bmc_pic_type              hdr_pic,
	input wire logic [bmc_pkg::INCR_W-1:0]        hdr_addr_incr,
	input wire logic                              vec_valid,
	input wire logic                              vec_skipped,
	input wire logic                              vec_use_fwd,
	input wire logic                              vec_use_bwd,
	input wire logic signed [3:0][bmc_pkg::VW-1:0] vec_recon,
	input wire logic signed [3:0][bmc_pkg::VW-1:0] vec_whole,
	input wire logic [3:0]                        vec_half,
	input wire logic                              smp_valid,
	input wire logic                              smp_ready,
	input wire logic                              pix_valid,
	input wire logic                              pix_ready,
	input wire logic [bmc_pkg::PIX_W-1:0]         pix_data,
	input wire logic [bmc_pkg::BLK_W-1:0]         pix_blk
);
	bmc_pic_type pic_r;
	logic        take;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// picture type of the header last taken
	assign take = hdr_valid && hdr_ready && clk_en;
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pic_r <= PIC_I;
		end else if (take) begin
			pic_r <= hdr_pic;
		end
	end
	a_hdr_vec_lat: assert property (take && hdr_addr_incr == INCR_ONE |-> ##2 vec_valid && !vec_skipped)
		else $error("coded vectors late");
	a_skip_first: assert property (take && hdr_pic != PIC_I && hdr_addr_incr > INCR_ONE |-> ##2 vec_valid && vec_skipped)
		else $error("skip not first");
	a_vec_pulse: assert property (vec_valid |=> !vec_valid)
		else $error("vector strobe too long");
	a_half_split: assert property (vec_valid |-> vec_half == {vec_recon[3][0], vec_recon[2][0], vec_recon[1][0],
		vec_recon[0][0]} && vec_whole[FD] == {vec_recon[FD][VW-1], vec_recon[FD][VW-1:1]})
		else $error("whole or half part wrong");
	a_p_skip_zero: assert property (vec_valid && vec_skipped && pic_r == PIC_P |-> {vec_recon[FD], vec_recon[FR]} == '0)
		else $error("predicted skip vector not zero");
	a_b_skip_keep: assert property (vec_valid && vec_skipped && pic_r == PIC_B |-> vec_recon == $past(vec_recon)
		&& vec_use_fwd == $past(vec_use_fwd) && vec_use_bwd == $past(vec_use_bwd))
		else $error("skip changed type or vectors");
	a_hdr_busy: assert property (take |=> !hdr_ready [*2])
		else $error("header taken while busy");
	a_smp_phase: assert property (hdr_ready |-> !smp_ready)
		else $error("samples taken while idle");
	a_pix_follow: assert property (smp_valid && smp_ready && clk_en |=> pix_valid)
		else $error("sample lost");
	a_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data) && $stable(pix_blk))
		else $error("pixel dropped under stall");
endmodule
bind bmc_recon bmc_recon_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .hdr_valid(hdr_valid),
	.hdr_ready(hdr_ready), .hdr_pic(hdr_pic), .hdr_addr_incr(hdr_addr_incr), .vec_valid(vec_valid),
	.vec_skipped(vec_skipped), .vec_use_fwd(vec_use_fwd), .vec_use_bwd(vec_use_bwd), .vec_recon(vec_recon),
	.vec_whole(vec_whole), .vec_half(vec_half), .smp_valid(smp_valid), .smp_ready(smp_ready),
	.pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .pix_blk(pix_blk));

/* File: tb/bmc_recon_tb.sv */
`timescale 1ns/1ps
// self-checking bench for the reconstruction block
module bmc_recon_tb;
	import bmc_pkg::*;
	bmc_pic_type               hdr_pic;
	logic                      mclk, sys_rst, hdr_valid, hdr_ready, hdr_first_in_slice, hdr_intra, slow, fp;
	logic                      hdr_motion_fwd, hdr_motion_bwd, vec_valid, vec_skipped, vec_use_fwd, vec_use_bwd;
	logic                      smp_valid, smp_ready, smp_last, smp_coded, pix_valid, pix_ready, pix_last;
	logic [INCR_W-1:0]         hdr_addr_incr;
	logic [FC_W-1:0]           fc;
	logic signed [4:0]         fhc, bhc;
	logic [RES_W-1:0]          rs;
	logic [POS_W-1:0]          row, pix_row, pix_col;
	logic signed [3:0][VW-1:0] vec_recon, vec_whole;
	logic [3:0]                vec_half;
	logic [BLK_W-1:0]          smp_blk, pix_blk;
	logic [4*PIX_W-1:0]        smp_ref;
	logic signed [8:0]         smp_resid;
	logic [PIX_W-1:0]          pix_data;
	logic [24:0]               q[$];
	logic [24:0]               e, m;
	int                        bad_count, n_compared;
	bmc_recon dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
		.hdr_pic(hdr_pic), .hdr_first_in_slice(hdr_first_in_slice), .hdr_addr_incr(hdr_addr_incr),
		.hdr_intra(hdr_intra), .hdr_motion_fwd(hdr_motion_fwd), .hdr_motion_bwd(hdr_motion_bwd),
		.hdr_fwd_f_code(fc), .hdr_bwd_f_code(fc), .hdr_fwd_full_pel(fp), .hdr_bwd_full_pel(fp),
		.hdr_fwd_h_code(fhc), .hdr_fwd_h_resid(rs), .hdr_fwd_v_code(fhc), .hdr_fwd_v_resid(rs),
		.hdr_bwd_h_code(bhc), .hdr_bwd_h_resid(rs), .hdr_bwd_v_code(bhc), .hdr_bwd_v_resid(rs),
		.hdr_block_row_index(row), .hdr_block_col_index(~row), .vec_valid(vec_valid), .vec_skipped(vec_skipped),
		.vec_use_fwd(vec_use_fwd), .vec_use_bwd(vec_use_bwd), .vec_recon(vec_recon), .vec_whole(vec_whole),
		.vec_half(vec_half), .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_last(smp_last),
		.smp_blk(smp_blk), .smp_coded(smp_coded), .smp_past_a(smp_ref[31:24]), .smp_past_b(smp_ref[23:16]),
		.smp_fut_a(smp_ref[15:8]), .smp_fut_b(smp_ref[7:0]), .smp_resid(smp_resid), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .pix_data(pix_data), .pix_block_row_index(pix_row),
		.pix_block_col_index(pix_col), .pix_blk(pix_blk), .pix_last(pix_last));
	bmc_src_model src (.mclk(mclk), .slow(slow), .smp_ready(smp_ready), .smp_valid(smp_valid),
		.smp_last(smp_last), .smp_blk(smp_blk), .smp_coded(smp_coded), .smp_ref(smp_ref), .smp_resid(smp_resid));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic give_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
		n_compared++;
		if (g !== x) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic quit(input string nm);
		bad_count++;
		$display("Error %s expected handshake seen timeout", nm);
		give_verdict();
	endtask
	// header offered until taken
	task automatic hdr(input bmc_pic_type p, input logic [3:0] fl, input logic [10:0] inc, input logic [2:0] c,
		input logic [4:0] f, input logic [4:0] b, input logic [5:0] r, input logic [5:0] rw);
		int i;
		hdr_valid <= 1'b1;
		hdr_pic <= p;
		{hdr_first_in_slice, hdr_intra, hdr_motion_fwd, hdr_motion_bwd} <= fl;
		{hdr_addr_incr, fc, fhc, bhc, rs, row} <= {inc, c, f, b, r, rw};
		for (i = 0; i < 40; i++) begin
			@(posedge mclk);
			if (hdr_ready === 1'b1) break;
		end
		hdr_valid <= 1'b0;
		if (i == 40) quit("hdr_ready");
	endtask
	task automatic wv();
		int i;
		for (i = 0; i < 40; i++) begin
			@(posedge mclk);
			if (vec_valid === 1'b1) break;
		end
		if (i == 40) quit("vec_valid");
	endtask
	task automatic chkv(input logic [2:0] fl, input logic [12:0] f, input logic [12:0] b);
		wv();
		chk("vectors", {fl, b, b, f, f}, {vec_skipped, vec_use_fwd, vec_use_bwd, vec_recon});
	endtask
	task automatic px(input logic [2:0] bk, input logic cd, input logic [31:0] rf, input logic [8:0] rd,
		input logic lst, input logic [7:0] x, input logic ps);
		logic tmo;
		q.push_back({ps, lst, row, ~row, bk, x});
		src.put(bk, cd, rf, rd, lst, tmo);
		if (tmo) quit("smp_ready");
	endtask
	task automatic drain();
		int i;
		for (i = 0; i < 60 && q.size() > 0; i++) @(posedge mclk);
		if (q.size() > 0) quit("pixel count");
	endtask
	// pixels leave in order; position only checked outside skipped macroblocks
	always @(posedge mclk) begin
		if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
			e = q.pop_front();
			m = e[24] ? 25'h1FFFFFF : 25'h8007FF;
			chk("pixel", e & m, {1'b1, pix_last, pix_row, pix_col, pix_blk, pix_data} & m);
		end
	end
	// both directions, extremes of residual, sink stalled into a full buffer
	task automatic t_both();
		hdr(PIC_B, 4'hB, 11'h001, 3'h1, 5'h02, 5'h1E, 6'h00, 6'h05);
		chkv(3'h3, 13'h0002, 13'h1FFE);
		pix_ready <= 1'b0;
		px(3'h0, 1'b1, 32'h64003300, 9'h0FF, 1'b0, 8'hFF, 1'b1);
		px(3'h1, 1'b1, 32'h64003300, 9'h100, 1'b0, 8'h00, 1'b1);
		repeat (3) @(posedge mclk);
		chk("smp_ready when full", 64'h0, smp_ready);
		pix_ready <= 1'b1;
		px(3'h2, 1'b0, 32'h64003300, 9'h064, 1'b1, 8'h4C, 1'b1);
		drain();
	endtask
	// backward only with larger scale, slow source
	task automatic t_bwd();
		hdr(PIC_B, 4'h1, 11'h001, 3'h2, 5'h00, 5'h01, 6'h00, 6'h06);
		chkv(3'h1, 13'h0002, 13'h1FFF);
		slow = 1'b1;
		px(3'h3, 1'b1, 32'hC8C80A0D, 9'h003, 1'b1, 8'h0F, 1'b1);
		slow = 1'b0;
		drain();
	endtask
	// skipped one ahead of a forward-only block
	task automatic t_bskip();
		hdr(PIC_B, 4'h2, 11'h002, 3'h1, 5'h01, 5'h00, 6'h00, 6'h07);
		chkv(3'h5, 13'h0002, 13'h1FFF);
		px(3'h0, 1'b1, 32'h00002828, 9'h032, 1'b1, 8'h28, 1'b0);
		chkv(3'h2, 13'h0003, 13'h1FFF);
		px(3'h4, 1'b1, 32'h5A5B0000, 9'h000, 1'b1, 8'h5B, 1'b1);
		drain();
	endtask
	// intra block, then a coded block sees cleared vectors
	task automatic t_intra();
		hdr(PIC_B, 4'h4, 11'h001, 3'h1, 5'h00, 5'h00, 6'h00, 6'h08);
		wv();
		px(3'h5, 1'b1, 32'hC8C8C8C8, 9'h007, 1'b1, 8'h07, 1'b1);
		hdr(PIC_B, 4'h2, 11'h001, 3'h1, 5'h01, 5'h00, 6'h00, 6'h09);
		chkv(3'h2, 13'h0001, 13'h0000);
		px(3'h6, 1'b1, 32'h1E1F0000, 9'h000, 1'b1, 8'h1F, 1'b1);
		drain();
	endtask
	// intra picture, then a predicted skip and a coded block
	task automatic t_pskip();
		hdr(PIC_I, 4'hC, 11'h001, 3'h1, 5'h00, 5'h00, 6'h00, 6'h0A);
		wv();
		px(3'h7, 1'b1, 32'h50505050, 9'h080, 1'b1, 8'h80, 1'b1);
		fp <= 1'b1;
		hdr(PIC_P, 4'hA, 11'h002, 3'h1, 5'h01, 5'h00, 6'h00, 6'h0B);
		wv();
		chk("skip vector", {1'b1, 26'h0000000}, {vec_skipped, vec_recon[FD], vec_recon[FR]});
		px(3'h0, 1'b1, 32'h3C000000, 9'h009, 1'b1, 8'h3C, 1'b0);
		wv();
		chk("coded vector", {1'b0, 26'h0004002}, {vec_skipped, vec_recon[FD], vec_recon[FR]});
		px(3'h1, 1'b1, 32'h14000000, 9'h1FB, 1'b1, 8'h0F, 1'b1);
		drain();
		fp <= 1'b0;
	endtask
	initial begin
		sys_rst = 1'b1;
		hdr_valid = 1'b0;
		pix_ready = 1'b1;
		slow = 1'b0;
		fp = 1'b0;
		hdr_pic = PIC_I;
		{hdr_first_in_slice, hdr_intra, hdr_motion_fwd, hdr_motion_bwd} = 4'h0;
		{hdr_addr_incr, fc, fhc, bhc, rs, row} = {11'h001, 3'h1, 22'h000000};
		bad_count = 0;
		n_compared = 0;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		chk("reset outputs", 64'h8, {hdr_ready, vec_valid, smp_ready, pix_valid});
		t_both();
		t_bwd();
		t_bskip();
		t_intra();
		t_pskip();
		give_verdict();
	end
endmodule

/* File: tb/bmc_src_model.sv */
`timescale 1ns/1ps
// reference memory and residual source, one sample per call
module bmc_src_model
	import bmc_pkg::*;
(
	input  wire logic                              mclk,
	input  wire logic                              slow,
	input  wire logic                              smp_ready,
	output logic                                   smp_valid,
	output logic                                   smp_last,
	output logic [bmc_pkg::BLK_W-1:0]              smp_blk,
	output logic                                   smp_coded,
	output logic [4*bmc_pkg::PIX_W-1:0]            smp_ref,
	output logic signed [bmc_pkg::RESID_W-1:0]     smp_resid
);
	initial begin
		smp_valid = 1'b0;
		{smp_last, smp_blk, smp_coded, smp_ref, smp_resid} = '0;
	end
	// sample held until taken; after a last sample the released lines show the inverse word
	task automatic put(input logic [2:0] bk, input logic cd, input logic [31:0] rf, input logic [8:0] rd,
		input logic lst, output logic tmo);
		int i;
		if (slow) begin
			smp_valid <= 1'b0;
			@(posedge mclk);
		end
		smp_valid <= 1'b1;
		{smp_blk, smp_coded, smp_ref, smp_resid, smp_last} <= {bk, cd, rf, rd, lst};
		for (i = 0; i < 200; i++) begin
			@(posedge mclk);
			if (smp_ready === 1'b1) break;
		end
		tmo = (i == 200);
		if (lst) begin
			smp_valid <= 1'b0;
			{smp_ref, smp_resid} <= ~{rf, rd};
			@(posedge mclk);
		end
	endtask
endmodule
